//--- bench/sgcr_regs_tb.sv
// Purpose: self-checking bench for the general config registers
// Assumes: 10 MHz clock, remote answers from sgcr_rmt_model
// Notes: bench model in plain variables, compared at every result
`timescale 1ns/1ps
module sgcr_regs_tb;
    logic ref_clk_i, rst_i, sel, reg_wr, reg_rd, rwr, rport, rns;
    logic acc, aport, amatch, resp, rnack, ack, nack, fwd;
    logic [7:0] addr, wdata, rdata;
    logic [3:0] dly;
    sgcr_pkg::sgcr_cfg_t cfg;
    int n_errors = 0, checks = 0, seed = 59004, na, nn, d;
    logic [7:0] gcfg = 8'hD2, msel = 8'h80;
    logic aa[2] = '{1'b0, 1'b0}, pt[2] = '{1'b0, 1'b0};
    sgcr_regs uut (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
        .second_port_select_i(sel), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd),
        .reg_addr_i(addr), .reg_wdata_i(wdata), .rmt_wr_i(rwr),
        .rmt_port_i(rport), .rmt_resp_i(resp), .rmt_nack_i(rnack),
        .acc_start_i(acc), .acc_port_i(aport), .alias_match_i(amatch),
        .cfg_o(cfg), .reg_rdata_o(rdata), .master_ack_o(ack),
        .master_nack_o(nack), .forward_o(fwd));
    sgcr_rmt_model rmt (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .go_i(rwr),
        .nack_sel_i(rns), .delay_i(dly), .resp_o(resp), .nack_o(rnack));
    ////////////////////////////////////////////////////////////////////
    // shared compare
    task automatic chk(input logic [8:0] got, input logic [8:0] exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : chk
    // register write, model updated alongside
    task automatic wr(input logic s, input logic [7:0] a, input logic [7:0] v);
        @(posedge ref_clk_i);
        sel <= s;
        reg_wr <= 1'b1;
        addr <= a;
        wdata <= v;
        @(posedge ref_clk_i);
        reg_wr <= 1'b0;
        if (a == 8'h03) begin
            gcfg = 8'h40 | (v & 8'h92);
            aa[s] = v[5];
            pt[s] = v[3];
        end
        if (a == 8'h04) msel = v & 8'hA0;
    endtask : wr
    // register read and check of read data and steering outputs
    task automatic rd(input logic s, input logic [7:0] a);
        logic [7:0] e;
        @(posedge ref_clk_i);
        sel <= s;
        reg_rd <= 1'b1;
        addr <= a;
        @(posedge ref_clk_i);
        reg_rd <= 1'b0;
        #1;
        e = a == 8'h03 ? gcfg | {2'h0, aa[s], 1'b0, pt[s], 3'h0} :
            a == 8'h04 ? msel : 8'h00;
        chk({1'b0, rdata}, {1'b0, e});
        chk(cfg, {gcfg[7], gcfg[4], gcfg[1], msel[7], msel[5],
            aa[1], aa[0], pt[1], pt[0]});
    endtask : rd
    // closing verdict
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : end_of_test
    ////////////////////////////////////////////////////////////////////
    // clock
    initial begin
        ref_clk_i = 1'b0;
        forever #50 ref_clk_i = ~ref_clk_i;
    end
    // main sequence
    initial begin
        {rst_i, sel, reg_wr, reg_rd, rwr, rport, rns, acc, aport} = 9'h100;
        {amatch, addr, wdata, dly} = 21'h0;
        repeat (5) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        for (int i = 0; i < 4; i++) rd(i[0], i[1] ? 8'h04 : 8'h03);
        $display("reset value test done");
        for (int i = 0; i < 24; i++) begin
            d = $random(seed);
            wr(d[8], 8'h03 + 8'(d[10:9] % 3), d[7:0]);
            rd(d[11], 8'h03 + 8'(d[13:12] % 3));
            rd(d[14], 8'h03);
        end
        $display("register access test done");
        // reset again in mid-run; defaults must return
        @(posedge ref_clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        gcfg = 8'hD2;
        msel = 8'h80;
        aa = '{1'b0, 1'b0};
        pt = '{1'b0, 1'b0};
        for (int i = 0; i < 4; i++) rd(i[0], i[1] ? 8'h04 : 8'h03);
        $display("mid-run reset test done");
        for (int i = 0; i < 8; i++) begin
            d = $random(seed);
            wr(i[0], 8'h03, (d[7:0] & 8'hD7) | {2'h0, i[1], 5'h0});
            @(posedge ref_clk_i);
            rwr <= 1'b1;
            rport <= i[0];
            rns <= i[2];
            dly <= d[11:8] & 4'h7;
            @(posedge ref_clk_i);
            rwr <= 1'b0;
            na = 0;
            nn = 0;
            for (int k = 0; k < 20; k++) begin
                #1;
                na += (ack === 1'b1) ? 1 : (ack === 1'b0) ? 0 : 100;
                nn += (nack === 1'b1) ? 1 : (nack === 1'b0) ? 0 : 100;
                @(posedge ref_clk_i);
            end
            chk(9'(na), i[1] ? 9'h1 : 9'(!i[2]));
            chk(9'(nn), i[1] ? 9'h0 : 9'(i[2]));
        end
        $display("remote acknowledge test done");
        wr(1'b0, 8'h03, 8'hDA);
        for (int i = 0; i < 12; i++) begin
            d = $random(seed);
            @(posedge ref_clk_i);
            acc <= 1'b1;
            aport <= d[0];
            amatch <= d[1];
            @(posedge ref_clk_i);
            acc <= 1'b0;
            #1;
            chk({8'h0, fwd}, {8'h0, d[1] & pt[d[0]]});
        end
        $display("forwarding test done");
        end_of_test();
    end
endmodule : sgcr_regs_tb

//--- bench/sgcr_rmt_model.sv
// Purpose: remote device answering forwarded writes
// Assumes: one write pending at a time
// Notes: nack line shows inverse of last value outside answers
`timescale 1ns/1ps
module sgcr_rmt_model (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic go_i,
    input wire logic nack_sel_i,
    input wire logic [3:0] delay_i,
    output logic resp_o,
    output logic nack_o
);
    logic busy;
    logic last;
    logic [3:0] cnt;
    // answer delay_i+1 cycles after the write, never in the same cycle
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            busy <= 1'b0;
            cnt <= 4'h0;
            last <= 1'b0;
            resp_o <= 1'b0;
        end else if (go_i) begin
            busy <= 1'b1;
            cnt <= delay_i;
            last <= nack_sel_i;
            resp_o <= 1'b0;
        end else begin
            resp_o <= busy && cnt == 4'h0;
            if (cnt == 4'h0) busy <= 1'b0;
            else cnt <= cnt - 4'h1;
        end
    end
    // nack only meaningful with the answer pulse
    assign nack_o = resp_o ? last : ~last;
endmodule : sgcr_rmt_model

//--- logic/sgcr_pkg.sv
// Purpose: constants and types for the serializer general config registers
// Assumes: 8-bit register index, two link ports, 10 MHz ref_clk_i
// Notes: shared by the register bank and its assertions
//
// Notes on behaviour
// - config bit 7 enables back-channel crc checker; on at reset
// - bit 5 set: remote writes acknowledged at once, no remote wait
// - with auto-acknowledge on, remote nack never reaches local master
// - bit 4 set: reject sync/enable pulses under two pixel clocks
// - bit 3 set: alias-matched accesses forwarded to remote deserializer
// - bits 5 and 3 kept per port; port select picks the copy
// - bit 1 set: fall back to internal oscillator without pixel clock
// - mode select bit 7: failsafe level, 0 high, 1 low; low at reset
// - mode select bit 5 holds crc error counters cleared until written 0
// - general config resets to D2, mode select to 80
package sgcr_pkg;
    localparam int unsigned SGCR_ADDR_W = 8;
    localparam int unsigned SGCR_DATA_W = 8;
    localparam int unsigned SGCR_PORTS = 2;
    localparam logic [7:0] SGCR_GEN_CFG_ADDR = 8'h03;
    localparam logic [7:0] SGCR_MODE_SEL_ADDR = 8'h04;
    localparam logic [7:0] SGCR_GEN_CFG_RST = 8'hD2;
    localparam logic [7:0] SGCR_MODE_SEL_RST = 8'h80;
    // general configuration fields
    localparam int unsigned SGCR_CRC_EN_BIT = 7;
    localparam int unsigned SGCR_AUTO_ACK_BIT = 5;
    localparam int unsigned SGCR_FILTER_BIT = 4;
    localparam int unsigned SGCR_PASS_BIT = 3;
    localparam int unsigned SGCR_PCLK_AUTO_BIT = 1;
    // mode select fields
    localparam int unsigned SGCR_FAILSAFE_BIT = 7;
    localparam int unsigned SGCR_CRC_CLR_BIT = 5;
    // writable bits; the rest are reserved
    localparam logic [7:0] SGCR_GEN_CFG_WMASK = 8'hBA;
    localparam logic [7:0] SGCR_MODE_SEL_WMASK = 8'hA0;

    typedef struct packed {
        logic crc_check_en;
        logic filter_en;
        logic pclk_auto;
        logic failsafe_low;
        logic crc_cnt_clear;
        logic [1:0] auto_ack;
        logic [1:0] pass_through;
    } sgcr_cfg_t;

    typedef enum logic [0:0] {
        SGCR_ACK_IDLE = 1'b0,
        SGCR_ACK_WAIT = 1'b1
    } sgcr_ack_state_t;
endpackage : sgcr_pkg

//--- logic/sgcr_regs.sv
// Purpose: general configuration and mode select registers of a serializer
// Assumes: register port driven by the serial bus slave on ref_clk_i
// Notes: also decides local ack/nack and forwarding for remote accesses
`timescale 1ns/1ps
module sgcr_regs (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic second_port_select_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic rmt_wr_i,
    input wire logic rmt_port_i,
    input wire logic rmt_resp_i,
    input wire logic rmt_nack_i,
    input wire logic acc_start_i,
    input wire logic acc_port_i,
    input wire logic alias_match_i,
    output sgcr_pkg::sgcr_cfg_t cfg_o,
    output logic [7:0] reg_rdata_o,
    output logic master_ack_o,
    output logic master_nack_o,
    output logic forward_o
);
    logic crc_check_en;
    logic filter_en;
    logic pclk_auto;
    logic failsafe_low;
    logic crc_cnt_clear;
    logic [1:0] auto_ack;
    logic [1:0] pass_through;
    logic gen_wr;
    logic mode_wr;
    logic wait_auto;
    sgcr_pkg::sgcr_ack_state_t ack_state;

    // one clock and one reset for every check below
    default clocking sgcr_chk_cb @(posedge ref_clk_i);
    endclocking
    default disable iff (rst_i);

    ////////////////////////////////////////////////////////////////////////
    // read-back composition, used only for the read port
    function automatic logic [7:0] sgcr_gen_view(input logic crc,
        input logic filt, input logic pclk, input logic aa, input logic pt);
        logic [7:0] v;
        v = sgcr_pkg::SGCR_GEN_CFG_RST & ~sgcr_pkg::SGCR_GEN_CFG_WMASK;
        v[sgcr_pkg::SGCR_CRC_EN_BIT] = crc;
        v[sgcr_pkg::SGCR_FILTER_BIT] = filt;
        v[sgcr_pkg::SGCR_PCLK_AUTO_BIT] = pclk;
        v[sgcr_pkg::SGCR_AUTO_ACK_BIT] = aa;
        v[sgcr_pkg::SGCR_PASS_BIT] = pt;
        return v;
    endfunction : sgcr_gen_view

    function automatic logic [7:0] sgcr_mode_view(input logic fs,
        input logic clr);
        logic [7:0] v;
        v = sgcr_pkg::SGCR_MODE_SEL_RST & ~sgcr_pkg::SGCR_MODE_SEL_WMASK;
        v[sgcr_pkg::SGCR_FAILSAFE_BIT] = fs;
        v[sgcr_pkg::SGCR_CRC_CLR_BIT] = clr;
        return v;
    endfunction : sgcr_mode_view

    // address decode
    assign gen_wr = reg_wr_i && (reg_addr_i == sgcr_pkg::SGCR_GEN_CFG_ADDR);
    assign mode_wr = reg_wr_i
        && (reg_addr_i == sgcr_pkg::SGCR_MODE_SEL_ADDR);

    ////////////////////////////////////////////////////////////////////////
    // shared general configuration bits
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            crc_check_en <=
                sgcr_pkg::SGCR_GEN_CFG_RST[sgcr_pkg::SGCR_CRC_EN_BIT];
            filter_en <=
                sgcr_pkg::SGCR_GEN_CFG_RST[sgcr_pkg::SGCR_FILTER_BIT];
            pclk_auto <=
                sgcr_pkg::SGCR_GEN_CFG_RST[sgcr_pkg::SGCR_PCLK_AUTO_BIT];
        end else if (gen_wr) begin
            crc_check_en <= reg_wdata_i[sgcr_pkg::SGCR_CRC_EN_BIT];
            filter_en <= reg_wdata_i[sgcr_pkg::SGCR_FILTER_BIT];
            pclk_auto <= reg_wdata_i[sgcr_pkg::SGCR_PCLK_AUTO_BIT];
        end
    end

    // per-port copies of auto-acknowledge and pass-through
    for (genvar p = 0; p < sgcr_pkg::SGCR_PORTS; p++) begin : g_port
        always_ff @(posedge ref_clk_i or posedge rst_i) begin
            if (rst_i) begin
                auto_ack[p] <=
                    sgcr_pkg::SGCR_GEN_CFG_RST[sgcr_pkg::SGCR_AUTO_ACK_BIT];
                pass_through[p] <=
                    sgcr_pkg::SGCR_GEN_CFG_RST[sgcr_pkg::SGCR_PASS_BIT];
            end else if (gen_wr && (second_port_select_i == 1'(p))) begin
                auto_ack[p] <=
                    reg_wdata_i[sgcr_pkg::SGCR_AUTO_ACK_BIT];
                pass_through[p] <=
                    reg_wdata_i[sgcr_pkg::SGCR_PASS_BIT];
            end
        end
    end

    // mode select bits; counter clear is a plain level, not self-clearing
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            failsafe_low <=
                sgcr_pkg::SGCR_MODE_SEL_RST[sgcr_pkg::SGCR_FAILSAFE_BIT];
            crc_cnt_clear <=
                sgcr_pkg::SGCR_MODE_SEL_RST[sgcr_pkg::SGCR_CRC_CLR_BIT];
        end else if (mode_wr) begin
            failsafe_low <= reg_wdata_i[sgcr_pkg::SGCR_FAILSAFE_BIT];
            crc_cnt_clear <= reg_wdata_i[sgcr_pkg::SGCR_CRC_CLR_BIT];
        end
    end

    // steering outputs toward the functional blocks
    assign cfg_o.crc_check_en = crc_check_en;
    assign cfg_o.filter_en = filter_en;
    assign cfg_o.pclk_auto = pclk_auto;
    assign cfg_o.failsafe_low = failsafe_low;
    assign cfg_o.crc_cnt_clear = crc_cnt_clear;
    assign cfg_o.auto_ack = auto_ack;
    assign cfg_o.pass_through = pass_through;

    ////////////////////////////////////////////////////////////////////////
    // registered read data; reserved bits show reset value, unmapped reads 0
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            reg_rdata_o <= 8'h00;
        end else if (reg_rd_i) begin
            case (reg_addr_i)
                sgcr_pkg::SGCR_GEN_CFG_ADDR: begin
                    reg_rdata_o <= sgcr_gen_view(crc_check_en, filter_en,
                        pclk_auto, auto_ack[second_port_select_i],
                        pass_through[second_port_select_i]);
                end
                sgcr_pkg::SGCR_MODE_SEL_ADDR: begin
                    reg_rdata_o <= sgcr_mode_view(failsafe_low,
                        crc_cnt_clear);
                end
                default: begin
                    reg_rdata_o <= 8'h00;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // remote write acknowledge policy
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            ack_state <= sgcr_pkg::SGCR_ACK_IDLE;
            wait_auto <= 1'b0;
            master_ack_o <= 1'b0;
            master_nack_o <= 1'b0;
        end else begin
            master_ack_o <= 1'b0;
            master_nack_o <= 1'b0;
            case (ack_state)
                sgcr_pkg::SGCR_ACK_IDLE: begin
                    if (rmt_wr_i) begin
                        ack_state <= sgcr_pkg::SGCR_ACK_WAIT;
                        wait_auto <= auto_ack[rmt_port_i];
                        master_ack_o <= auto_ack[rmt_port_i];
                    end
                end
                sgcr_pkg::SGCR_ACK_WAIT: begin
                    if (rmt_resp_i) begin
                        ack_state <= sgcr_pkg::SGCR_ACK_IDLE;
                        // remote answer is swallowed once acked early
                        master_ack_o <= !wait_auto && !rmt_nack_i;
                        master_nack_o <= !wait_auto && rmt_nack_i;
                    end
                end
                default: begin
                    ack_state <= sgcr_pkg::SGCR_ACK_IDLE;
                end
            endcase
        end
    end

    // pass-through forwarding of alias-matched accesses
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            forward_o <= 1'b0;
        end else begin
            forward_o <= acc_start_i && alias_match_i
                && pass_through[acc_port_i];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    reset_values_a: assert property ($fell(rst_i) |->
        crc_check_en && filter_en && pclk_auto && failsafe_low
        && !crc_cnt_clear && auto_ack == 2'b00 && pass_through == 2'b00)
        else $error("register reset value wrong");
    crc_enable_a: assert property (gen_wr |=> cfg_o.crc_check_en
        == $past(reg_wdata_i[sgcr_pkg::SGCR_CRC_EN_BIT]))
        else $error("crc checker enable not taken");
    early_ack_a: assert property (rmt_wr_i && auto_ack[rmt_port_i]
        && ack_state == sgcr_pkg::SGCR_ACK_IDLE |=> master_ack_o)
        else $error("auto acknowledge missing");
    nack_hidden_a: assert property (wait_auto
        && ack_state == sgcr_pkg::SGCR_ACK_WAIT |=> !master_nack_o)
        else $error("remote nack leaked to master");
    nack_passed_a: assert property (!wait_auto && rmt_resp_i
        && rmt_nack_i && ack_state == sgcr_pkg::SGCR_ACK_WAIT
        |=> master_nack_o && !master_ack_o)
        else $error("remote nack not passed on");
    filter_en_a: assert property (gen_wr |=> cfg_o.filter_en
        == $past(reg_wdata_i[sgcr_pkg::SGCR_FILTER_BIT]))
        else $error("filter enable not taken");
    forward_a: assert property (acc_start_i && alias_match_i
        && !pass_through[acc_port_i] |=> !forward_o)
        else $error("forward without pass-through");
    forward_on_a: assert property (acc_start_i && alias_match_i
        && pass_through[acc_port_i] |=> forward_o)
        else $error("pass-through access not forwarded");
    port_copy_a: assert property (gen_wr |=>
        ($past(second_port_select_i) ? $stable(auto_ack[0])
        && $stable(pass_through[0]) : $stable(auto_ack[1])
        && $stable(pass_through[1])))
        else $error("other port copy changed");
    pclk_auto_a: assert property (gen_wr |=> cfg_o.pclk_auto
        == $past(reg_wdata_i[sgcr_pkg::SGCR_PCLK_AUTO_BIT]))
        else $error("pixel clock auto-switch not taken");
    failsafe_a: assert property (mode_wr |=> cfg_o.failsafe_low
        == $past(reg_wdata_i[sgcr_pkg::SGCR_FAILSAFE_BIT]))
        else $error("failsafe level not taken");
    clear_hold_a: assert property (crc_cnt_clear && !mode_wr
        |=> crc_cnt_clear)
        else $error("counter clear dropped by itself");
    reserved_rd_a: assert property (reg_rd_i
        && reg_addr_i == sgcr_pkg::SGCR_MODE_SEL_ADDR
        |=> (reg_rdata_o & ~sgcr_pkg::SGCR_MODE_SEL_WMASK)
        == (sgcr_pkg::SGCR_MODE_SEL_RST & ~sgcr_pkg::SGCR_MODE_SEL_WMASK))
        else $error("reserved bits read wrong");
    reserved_gen_a: assert property (reg_rd_i
        && reg_addr_i == sgcr_pkg::SGCR_GEN_CFG_ADDR
        |=> (reg_rdata_o & ~sgcr_pkg::SGCR_GEN_CFG_WMASK)
        == (sgcr_pkg::SGCR_GEN_CFG_RST & ~sgcr_pkg::SGCR_GEN_CFG_WMASK))
        else $error("reserved config bits read wrong");
    early_ack_c: cover property (@(posedge ref_clk_i) disable iff (rst_i)
        rmt_wr_i && auto_ack[rmt_port_i] ##1 master_ack_o);
    remote_nack_c: cover property (@(posedge ref_clk_i) disable iff (rst_i)
        master_nack_o);
    forward_c: cover property (@(posedge ref_clk_i) disable iff (rst_i)
        forward_o);
    port1_wr_c: cover property (@(posedge ref_clk_i) disable iff (rst_i)
        gen_wr && second_port_select_i);
endmodule : sgcr_regs
